// >>> common/act_pkg.sv
package act_pkg;
   localparam int ACT_STAGES = 12;
   localparam int ACT_DEPTH = 4;
   // register indexes; the byte address is four times the index
   localparam logic [11:0] ACT_IDX_SKIP = 12'h001;
   localparam logic [11:0] ACT_IDX_FAST = 12'h002;
   localparam logic [11:0] ACT_IDX_CTRL1 = 12'h003;
   localparam logic [11:0] ACT_IDX_MODE = 12'h005;
   localparam logic [11:0] ACT_IDX_STAT = 12'h006;
   localparam logic [11:0] ACT_IDX_STAGE_BASE = 12'h100;
   localparam logic [11:0] ACT_IDX_STAGE_END = 12'h160;
   // word offsets inside one stage block of eight words
   localparam logic [2:0] ACT_W_POS = 3'h0;
   localparam logic [2:0] ACT_W_NEG = 3'h1;
   localparam logic [2:0] ACT_W_SENS = 3'h2;
   localparam logic [2:0] ACT_W_AMB = 3'h3;
   localparam logic [2:0] ACT_W_UPPER = 3'h4;
   localparam logic [2:0] ACT_W_LOWER = 3'h5;
   // field positions
   localparam int ACT_FP_LSB = 12;
   localparam int ACT_LP_LSB = 14;
   localparam int ACT_MARGIN_LSB = 8;
   localparam int ACT_SENS_NEG_LSB = 4;
   localparam int ACT_MODE_LP = 0;
   localparam int ACT_MODE_EN = 1;
   // arithmetic shifts
   localparam int ACT_QUARTER_SH = 2;
   localparam int ACT_SIXTEENTH_SH = 4;
   localparam int ACT_AVG_SH = 2;
   localparam int ACT_DRIFT_SH = 2;
   localparam logic [1:0] ACT_FP_BASE_LOW = 2'h3;
   localparam logic [31:0] ACT_UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic {ACT_BUS_IDLE = 1'b0, ACT_BUS_ANSWER = 1'b1} act_bus_t;
   typedef logic [15:0] act_word_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } act_apb_req_t;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } act_apb_rsp_t;
   typedef struct packed {
      logic valid;
      logic [3:0] stage;
      act_word_t data;
      logic proximity;
   } act_cdc_t;
   typedef struct packed {
      act_bus_t bus;
      act_apb_rsp_t rsp;
      logic int_b;
      act_word_t skip;
      logic [3:0] fast;
      act_word_t ctrl1;
      logic [1:0] mode;
      logic [ACT_STAGES-1:0] stat;
      act_word_t [ACT_STAGES-1:0] pos;
      act_word_t [ACT_STAGES-1:0] neg;
      logic [ACT_STAGES-1:0][7:0] sens;
      act_word_t [ACT_STAGES-1:0][ACT_DEPTH-1:0] fifo;
      act_word_t [ACT_STAGES-1:0] amb;
      logic [ACT_STAGES-1:0][3:0] fcnt;
      logic [ACT_STAGES-1:0][4:0] scnt;
   } act_state_t;
   localparam act_state_t ACT_STATE_RST = '{bus: ACT_BUS_IDLE, int_b: 1'b1, default: '0};
endpackage : act_pkg

// >>> core/act_tracker.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
// Operation
// - compensation runs on a kept fast-tick sample once enabled, only while untouched
// - ambient level is the average of the newest result and three slow FIFO entries while nobody nears the sensor
// - interrupt goes low when a result passes the upper or lower limit
// - upper limit is ambient plus span/4 plus span/4 times positive sensitivity
// - lower limit is ambient plus span/4 plus (span-span/4)/16 times negative sensitivity
// - spans follow ambient drift and both limits are recomputed from them
// - per-stage compensation data and setup live in on-chip storage
// - per-stage slow FIFOs of four entries track ambient level
// - skip fields come from bits 13:12 and 15:14 of skip register
// - full power keeps one sample per four times skip-plus-one fast ticks
// - low power keeps one sample per low-power skip plus one fast ticks
// - push only when the result differs from last entry by over margin
// - host sets up and controls compensation through control registers
// - fast discard count comes from bits 3:0 of register two
// - slow filter updates only with margin comparator set and no proximity
module act_tracker
   import act_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // register bus
   input wire act_apb_req_t apb_req_in,
   output act_apb_rsp_t apb_rsp_out,
   // converter results
   input wire act_cdc_t cdc_in,
   // interrupt
   output logic int_b_out
);

   act_state_t q;
   act_state_t next_q;

   // every check below runs on the one clock and rests while reset is low
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   // bus decode
   logic [11:0] idx;
   logic [11:0] sidx;
   logic [3:0] st;
   logic [2:0] wsel;
   logic in_stage;
   logic hit;
   logic [31:0] rd_word;
   logic bus_wr;

   // per-stage results
   logic signed [19:0] upper [ACT_STAGES];
   logic signed [19:0] lower [ACT_STAGES];
   logic [ACT_STAGES-1:0] ex_hi;
   logic [ACT_STAGES-1:0] ex_lo;
   logic [ACT_STAGES-1:0] margin_ok;
   logic [ACT_STAGES-1:0] mine;
   logic [ACT_STAGES-1:0] tick;
   logic [ACT_STAGES-1:0] keep;
   logic [ACT_STAGES-1:0] push;
   logic [ACT_STAGES-1:0] set_flags;
   logic [ACT_STAGES-1:0] clr_flags;
   logic [17:0] avg_sum;
   logic [15:0] avg;
   logic signed [16:0] drift;
   logic signed [16:0] drift_q;

   assign idx = apb_req_in.paddr[13:2];
   assign sidx = idx - ACT_IDX_STAGE_BASE;
   assign st = sidx[6:3];
   assign wsel = sidx[2:0];
   assign in_stage = (idx >= ACT_IDX_STAGE_BASE) && (idx < ACT_IDX_STAGE_END);
   // write lands at the edge where the master sees pready high
   assign bus_wr = apb_req_in.psel && apb_req_in.penable && q.rsp.pready
                   && apb_req_in.pwrite && hit;

   // per-stage limits, comparators and slow FIFO gating
   for (genvar s = 0; s < ACT_STAGES; s++) begin : g_stage
      logic signed [19:0] amb_s;
      logic signed [19:0] pq;
      logic signed [19:0] nq;
      logic signed [19:0] nrest;
      logic signed [19:0] dat;
      logic [15:0] diff;
      logic [4:0] lim;
      assign amb_s = $signed({4'h0, q.amb[s]});
      assign dat = $signed({4'h0, cdc_in.data});
      assign pq = $signed({{4{q.pos[s][15]}}, q.pos[s]}) >>> ACT_QUARTER_SH;
      assign nq = $signed({{4{q.neg[s][15]}}, q.neg[s]}) >>> ACT_QUARTER_SH;
      assign nrest = ($signed({{4{q.neg[s][15]}}, q.neg[s]}) - nq) >>> ACT_SIXTEENTH_SH;
      // limits follow the current spans and ambient every cycle
      assign upper[s] = 20'(amb_s + pq + pq * $signed({16'h0, q.sens[s][3:0]}));
      assign lower[s] = 20'(amb_s + nq
                        + nrest * $signed({16'h0, q.sens[s][ACT_SENS_NEG_LSB+:4]}));
      assign ex_hi[s] = dat > upper[s];
      assign ex_lo[s] = dat < lower[s];
      // distance from last slow FIFO entry against the margin
      assign diff = (cdc_in.data >= q.fifo[s][0]) ? cdc_in.data - q.fifo[s][0]
                                                 : q.fifo[s][0] - cdc_in.data;
      assign margin_ok[s] = diff > {8'h00, q.ctrl1[ACT_MARGIN_LSB+:8]};
      assign mine[s] = cdc_in.valid && (cdc_in.stage == 4'(s));
      // fast tick every discard count plus one conversions
      assign tick[s] = q.fcnt[s] == q.fast;
      // keep one sample out of the skip window
      assign lim = q.mode[ACT_MODE_LP] ? {3'h0, q.skip[ACT_LP_LSB+:2]}
                                        : {1'b0, q.skip[ACT_FP_LSB+:2], ACT_FP_BASE_LOW};
      assign keep[s] = q.scnt[s] == lim;
      // untouched, no proximity, enabled, margin comparator set
      assign push[s] = mine[s] && tick[s] && keep[s] && q.mode[ACT_MODE_EN]
                       && !cdc_in.proximity && !(ex_hi[s] || ex_lo[s])
                       && margin_ok[s];

      a_prox_holds_fifo: assert property (
         mine[s] && cdc_in.proximity |=> $stable(q.fifo[s]))
         else $error("slow fifo moved during proximity");
      a_margin_holds_fifo: assert property (
         mine[s] && !margin_ok[s] |=> $stable(q.fifo[s]))
         else $error("slow fifo moved inside margin");
      a_skip_holds_fifo: assert property (
         mine[s] && !(tick[s] && keep[s]) |=> $stable(q.fifo[s]))
         else $error("skipped sample reached slow fifo");
      a_exceed_flags: assert property (
         mine[s] && (ex_hi[s] || ex_lo[s]) |=> q.stat[s] && !int_b_out)
         else $error("limit crossing not flagged");
      a_push_newest: assert property (push[s] |=> q.fifo[s][0] == $past(cdc_in.data))
         else $error("slow fifo did not take newest result");
      a_upper_above_amb: assert property (
         !q.pos[s][15] && !q.amb[s][15] |-> upper[s] >= $signed({4'h0, q.amb[s]}))
         else $error("upper limit below ambient");

      // flags stay until cleared, and only a crossing sets them
      a_flag_sticky: assert property (
         q.stat[s] && !clr_flags[s] |=> q.stat[s])
         else $error("status flag dropped without clear");
      a_flag_clears: assert property (
         clr_flags[s] && !set_flags[s] |=> !q.stat[s])
         else $error("status flag not cleared");
      a_flag_needs_cross: assert property (
         !q.stat[s] && !set_flags[s] |=> !q.stat[s])
         else $error("status flag set without crossing");

      // slow FIFO shifts on a push; ambient and spans follow it
      a_fifo_shifts: assert property (
         push[s] |=> q.fifo[s][1] == $past(q.fifo[s][0]))
         else $error("slow fifo did not shift");
      a_amb_from_avg: assert property (
         push[s] && !bus_wr |=> q.amb[s] == $past(avg))
         else $error("ambient not the slow fifo average");
      a_pos_follows: assert property (
         push[s] && !bus_wr |=> q.pos[s] == $past(q.pos[s]) - $past(drift_q[15:0]))
         else $error("positive span did not follow drift");
      a_neg_follows: assert property (
         push[s] && !bus_wr |=> q.neg[s] == $past(q.neg[s]) - $past(drift_q[15:0]))
         else $error("negative span did not follow drift");
      a_fast_restart: assert property (
         mine[s] && tick[s] |=> q.fcnt[s] == 4'h0)
         else $error("fast counter did not restart");
      a_fast_count: assert property (
         mine[s] && !tick[s] |=> q.fcnt[s] == $past(q.fcnt[s]) + 4'h1)
         else $error("fast counter did not advance");
      a_idle_stage_frozen: assert property (
         !mine[s] |=> $stable(q.fifo[s]))
         else $error("slow fifo moved without its conversion");
   end

   // average of the newest slow FIFO contents for the pushing stage
   always_comb begin
      avg_sum = 18'h00000;
      for (int s = 0; s < ACT_STAGES; s++) begin
         if (push[s]) begin
            avg_sum = {2'h0, cdc_in.data} + {2'h0, q.fifo[s][0]}
                      + {2'h0, q.fifo[s][1]} + {2'h0, q.fifo[s][2]};
         end
      end
      avg = 16'(avg_sum >> ACT_AVG_SH);
   end

   // register read mux
   always_comb begin
      rd_word = ACT_UNMAPPED_READ;
      hit = 1'b1;
      if (idx == ACT_IDX_SKIP) begin
         rd_word = {16'h0000, q.skip};
      end else if (idx == ACT_IDX_FAST) begin
         rd_word = {28'h0000000, q.fast};
      end else if (idx == ACT_IDX_CTRL1) begin
         rd_word = {16'h0000, q.ctrl1};
      end else if (idx == ACT_IDX_MODE) begin
         rd_word = {30'h00000000, q.mode};
      end else if (idx == ACT_IDX_STAT) begin
         rd_word = {20'h00000, q.stat};
      end else if (in_stage) begin
         case (wsel)
            ACT_W_POS: rd_word = {16'h0000, q.pos[st]};
            ACT_W_NEG: rd_word = {16'h0000, q.neg[st]};
            ACT_W_SENS: rd_word = {24'h000000, q.sens[st]};
            ACT_W_AMB: rd_word = {16'h0000, q.amb[st]};
            ACT_W_UPPER: rd_word = {{12{upper[st][19]}}, upper[st]};
            ACT_W_LOWER: rd_word = {{12{lower[st][19]}}, lower[st]};
            default: hit = 1'b0;
         endcase
      end else begin
         hit = 1'b0;
      end
   end

   // next state: conversions, then bus access
   always_comb begin
      next_q = q;
      set_flags = '0;
      clr_flags = '0;
      drift = 17'h00000;
      drift_q = 17'h00000;
      for (int s = 0; s < ACT_STAGES; s++) begin
         if (mine[s]) begin
            set_flags[s] = ex_hi[s] || ex_lo[s];
            next_q.fcnt[s] = tick[s] ? 4'h0 : q.fcnt[s] + 4'h1;
            if (tick[s]) begin
               next_q.scnt[s] = keep[s] ? 5'h00 : q.scnt[s] + 5'h01;
            end
         end
         // slow FIFO shift, ambient refresh and span follow-up
         if (push[s]) begin
            for (int d = ACT_DEPTH - 1; d > 0; d--) begin
               next_q.fifo[s][d] = q.fifo[s][d-1];
            end
            next_q.fifo[s][0] = cdc_in.data;
            next_q.amb[s] = avg;
            drift = $signed({1'b0, avg}) - $signed({1'b0, q.amb[s]});
            drift_q = drift >>> ACT_DRIFT_SH;
            next_q.pos[s] = q.pos[s] - drift_q[15:0];
            next_q.neg[s] = q.neg[s] - drift_q[15:0];
         end
      end
      // register writes; except for status clears, host writes win over the tracker in the same cycle
      if (bus_wr) begin
         if (idx == ACT_IDX_SKIP) begin
            next_q.skip = apb_req_in.pwdata[15:0];
         end else if (idx == ACT_IDX_FAST) begin
            next_q.fast = apb_req_in.pwdata[3:0];
         end else if (idx == ACT_IDX_CTRL1) begin
            next_q.ctrl1 = apb_req_in.pwdata[15:0];
         end else if (idx == ACT_IDX_MODE) begin
            next_q.mode = apb_req_in.pwdata[1:0];
         end else if (idx == ACT_IDX_STAT) begin
            clr_flags = apb_req_in.pwdata[ACT_STAGES-1:0];
         end else begin
            case (wsel)
               ACT_W_POS: next_q.pos[st] = apb_req_in.pwdata[15:0];
               ACT_W_NEG: next_q.neg[st] = apb_req_in.pwdata[15:0];
               ACT_W_SENS: next_q.sens[st] = apb_req_in.pwdata[7:0];
               ACT_W_AMB: next_q.amb[st] = apb_req_in.pwdata[15:0];
               default: next_q.amb = q.amb;
            endcase
         end
      end
      // a new crossing wins over a clear in the same cycle
      next_q.stat = (q.stat & ~clr_flags) | set_flags;
      next_q.int_b = ~|next_q.stat;
      // one wait state, then answer for one cycle
      case (q.bus)
         ACT_BUS_IDLE: begin
            if (apb_req_in.psel && apb_req_in.penable) begin
               next_q.bus = ACT_BUS_ANSWER;
               next_q.rsp.pready = 1'b1;
               next_q.rsp.prdata = apb_req_in.pwrite ? ACT_UNMAPPED_READ : rd_word;
               next_q.rsp.pslverr = !hit;
            end
         end
         ACT_BUS_ANSWER: begin
            next_q.bus = ACT_BUS_IDLE;
            next_q.rsp.pready = 1'b0;
            next_q.rsp.pslverr = 1'b0;
         end
         default: begin
            next_q.bus = ACT_BUS_IDLE;
            next_q.rsp.pready = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= ACT_STATE_RST;
      end else begin
         q <= next_q;
      end
   end

   assign apb_rsp_out = q.rsp;
   assign int_b_out = q.int_b;

   sequence s_access;
      apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready;
   endsequence
   sequence s_answer;
      apb_rsp_out.pready ##1 !apb_rsp_out.pready;
   endsequence

   a_bus_answer_cycle: assert property (s_access |=> s_answer)
      else $error("bus answer not one cycle after access");
   a_skip_field_write: assert property (bus_wr && idx == ACT_IDX_SKIP
      |=> q.skip[ACT_FP_LSB+:4] == $past(apb_req_in.pwdata[ACT_FP_LSB+:4]))
      else $error("skip fields not stored");
   a_int_from_flags: assert property (int_b_out == !(|q.stat) || $past(bus_wr))
      else $error("interrupt level disagrees with flags");
   a_disabled_frozen: assert property (!q.mode[ACT_MODE_EN] && !bus_wr |=> $stable(q.fifo))
      else $error("slow fifo moved while disabled");

   // answer strobe lasts one cycle and carries its status
   a_ready_pulse: assert property (
      apb_rsp_out.pready |=> !apb_rsp_out.pready)
      else $error("ready held longer than one cycle");
   a_error_with_ready: assert property (
      apb_rsp_out.pslverr |-> apb_rsp_out.pready)
      else $error("error flag without ready");
   a_unmapped_zero: assert property (
      apb_rsp_out.pslverr |-> apb_rsp_out.prdata == ACT_UNMAPPED_READ)
      else $error("unmapped access returned data");
   a_read_answer: assert property (
      s_access and !apb_req_in.pwrite |=> apb_rsp_out.prdata == $past(rd_word))
      else $error("read data not the addressed word");

   // register writes land whole
   a_skip_write: assert property (
      bus_wr && idx == ACT_IDX_SKIP |=> q.skip == $past(apb_req_in.pwdata[15:0]))
      else $error("skip register not stored");
   a_fast_write: assert property (
      bus_wr && idx == ACT_IDX_FAST |=> q.fast == $past(apb_req_in.pwdata[3:0]))
      else $error("fast discard count not stored");
   a_margin_write: assert property (
      bus_wr && idx == ACT_IDX_CTRL1 |=> q.ctrl1 == $past(apb_req_in.pwdata[15:0]))
      else $error("control register not stored");
   a_write_mode: assert property (
      bus_wr && idx == ACT_IDX_MODE |=> q.mode == $past(apb_req_in.pwdata[1:0]))
      else $error("mode register not stored");
   a_ignored_stage: assert property (
      cdc_in.valid && cdc_in.stage >= 4'(ACT_STAGES) && !bus_wr
      |=> $stable(q.stat) && $stable(q.amb))
      else $error("out of range stage changed state");

endmodule : act_tracker

// >>> dv/act_conv_model.sv
`timescale 1ns/10ps
module act_conv_model
   import act_pkg::*;
(
   // clock
   input wire logic clock_in,
   // converter results toward the tracker
   output act_cdc_t cdc_out
);
   // quiet lines before the first conversion
   initial cdc_out = '0;
   // one result strobe; afterwards the lines flip so a stale value never looks held
   task automatic conv(input logic [3:0] st, input act_word_t d, input logic px);
      @(posedge clock_in);
      cdc_out <= '{valid: 1'b1, stage: st, data: d, proximity: px};
      @(posedge clock_in);
      cdc_out <= '{valid: 1'b0, stage: ~st, data: ~d, proximity: ~px};
   endtask : conv
endmodule : act_conv_model

// >>> dv/act_tracker_test.sv
`timescale 1ns/10ps
module act_tracker_test;
   import act_pkg::*;
   logic clock;
   logic rst_b;
   act_apb_req_t req;
   act_apb_rsp_t rsp;
   act_cdc_t cdc;
   logic int_b;
   int err_count;
   int n_compared;
   // design and converter stand-in
   act_tracker dut (
      .clock_in(clock),
      .rst_b_in(rst_b),
      .apb_req_in(req),
      .apb_rsp_out(rsp),
      .cdc_in(cdc),
      .int_b_out(int_b)
   );
   act_conv_model conv_src (
      .clock_in(clock),
      .cdc_out(cdc)
   );
   // 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // verdict and end of run
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   // compare one value with its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // one apb transfer: setup, access held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      int k;
      @(posedge clock);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
      @(posedge clock);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
      if (k >= 20) begin
         err_count++;
         wrap_up();
      end
   endtask : xfer
   task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic er;
      xfer(1'b1, idx, wd, rd, er);
   endtask : wr
   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      xfer(1'b0, idx, 32'h0000_0000, rd, er);
      check(rd, exp);
   endtask : rd_chk
   // index of one word inside a stage block
   function automatic logic [11:0] sw(input logic [3:0] s, input logic [2:0] w);
      return ACT_IDX_STAGE_BASE + {5'h00, s, 3'h0} + {9'h000, w};
   endfunction : sw
   // main sequence
   initial begin
      logic [31:0] rd;
      logic er;
      rst_b = 1'b0;
      req = '0;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      check({31'h0, int_b}, 32'h0000_0001);
      rd_chk(ACT_IDX_SKIP, 32'h0000_0000);
      wr(ACT_IDX_SKIP, 32'h0000_F000);
      rd_chk(ACT_IDX_SKIP, 32'h0000_F000);
      xfer(1'b0, 12'h0FF, 32'h0000_0000, rd, er);
      check(rd, ACT_UNMAPPED_READ);
      check({31'h0, er}, 32'h0000_0001);
      // one-time setup: both skip fields zero, every conversion a fast tick
      wr(ACT_IDX_SKIP, 32'h0000_0000);
      wr(ACT_IDX_FAST, 32'h0000_000F);
      rd_chk(ACT_IDX_FAST, 32'h0000_000F);
      wr(ACT_IDX_FAST, 32'h0000_0000);
      wr(ACT_IDX_CTRL1, 32'h0000_1000);
      rd_chk(ACT_IDX_CTRL1, 32'h0000_1000);
      // stage 0 limits from spans, sensitivities and ambient
      wr(sw(4'h0, ACT_W_POS), 32'h0000_0103);
      wr(sw(4'h0, ACT_W_NEG), 32'h0000_FF00);
      wr(sw(4'h0, ACT_W_SENS), 32'h0000_0032);
      wr(sw(4'h0, ACT_W_AMB), 32'h0000_1000);
      rd_chk(sw(4'h0, ACT_W_UPPER), 32'h0000_10C0);
      rd_chk(sw(4'h0, ACT_W_LOWER), 32'h0000_0F9C);
      wr(sw(4'h0, ACT_W_AMB), 32'h0000_0000);
      rd_chk(sw(4'h0, ACT_W_UPPER), 32'h0000_00C0);
      // low power, compensation off: no ambient update
      wr(ACT_IDX_MODE, 32'h0000_0001);
      conv_src.conv(4'h0, 16'h0040, 1'b0);
      rd_chk(sw(4'h0, ACT_W_AMB), 32'h0000_0000);
      wr(ACT_IDX_MODE, 32'h0000_0003);
      rd_chk(ACT_IDX_MODE, 32'h0000_0003);
      // difference equal to the margin is not enough
      conv_src.conv(4'h0, 16'h0010, 1'b0);
      rd_chk(sw(4'h0, ACT_W_AMB), 32'h0000_0000);
      conv_src.conv(4'h0, 16'h0040, 1'b1);
      rd_chk(sw(4'h0, ACT_W_AMB), 32'h0000_0000);
      // accepted sample: ambient 0x40/4, spans drop by drift/4
      conv_src.conv(4'h0, 16'h0040, 1'b0);
      rd_chk(sw(4'h0, ACT_W_AMB), 32'h0000_0010);
      rd_chk(sw(4'h0, ACT_W_POS), 32'h0000_00FF);
      rd_chk(sw(4'h0, ACT_W_NEG), 32'h0000_FEFC);
      rd_chk(sw(4'h0, ACT_W_UPPER), 32'h0000_00CD);
      // crossing above the upper limit raises the interrupt, no ambient update
      conv_src.conv(4'h0, 16'h2000, 1'b0);
      repeat (2) @(posedge clock);
      check({31'h0, int_b}, 32'h0000_0000);
      rd_chk(sw(4'h0, ACT_W_AMB), 32'h0000_0010);
      // crossing below the lower limit on stage 1; stage 12 is ignored
      wr(sw(4'h1, ACT_W_AMB), 32'h0000_0100);
      conv_src.conv(4'h1, 16'h0080, 1'b0);
      conv_src.conv(4'hC, 16'h2000, 1'b0);
      rd_chk(ACT_IDX_STAT, 32'h0000_0003);
      wr(ACT_IDX_STAT, 32'h0000_0003);
      repeat (2) @(posedge clock);
      check({31'h0, int_b}, 32'h0000_0001);
      rd_chk(ACT_IDX_STAT, 32'h0000_0000);
      // full power, skips zero: only every fourth fast tick reaches the slow FIFO
      wr(ACT_IDX_MODE, 32'h0000_0002);
      wr(sw(4'h2, ACT_W_POS), 32'h0000_0400);
      repeat (3) conv_src.conv(4'h2, 16'h0040, 1'b0);
      rd_chk(sw(4'h2, ACT_W_AMB), 32'h0000_0000);
      conv_src.conv(4'h2, 16'h0040, 1'b0);
      rd_chk(sw(4'h2, ACT_W_AMB), 32'h0000_0010);
      rd_chk(sw(4'h2, ACT_W_POS), 32'h0000_03FC);
      wrap_up();
   end
endmodule : act_tracker_test
